// *** core/maiao_core.v ***
// Purpose: Executes data-move instructions written over Avalon-MM.
// Assumes: One clock; software writes one instruction word at a time.
// Notes:   Data memory is a local array; addresses above it read zero.
//
// Functional notes
// - Indirect read loads W and sets Z; indirect write stores W only.
// - One selector bit picks a pointer; two bits pick the mode.
// - Mode 00 preinc, 01 predec, 10 postinc, 11 postdec.
// - Pre-modes adjust then access; post-modes access then adjust.
// - Relative form adds signed offset -32..31; pointer unchanged.
// - Pointers are 16 bits and wrap modulo 65536.
// - Indirect locations hold nothing; Store to them goes through the pointer, other writes to them are dropped.
// - Load-bank puts a 5-bit literal into the bank register, no flags.
// - Load-page puts a 7-bit literal into the page latch, no flags.
// - Load-literal puts an 8-bit literal into W in one cycle, no flags.
// - Store copies W to a 7-bit addressed file register, no flags.
// - Pointer adjustment never touches any status flag.
`timescale 1ns/1ns
`default_nettype none
`include "maiao_defs.vh"

module maiao_core #(
  parameter MEM_AW = 8
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        arst_n,
  // Avalon-MM slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest
);

  // ========================================================
  // Helper functions

  // Merge write data into an old word under the byte enables
  function [31:0] be_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  be;
    integer i;
    begin
      be_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          be_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // Merge the two low lanes of write data into a 16-bit register
  function [15:0] merge16;
    input [15:0] old_val;
    input [31:0] new_val;
    input [3:0]  be;
    begin
      merge16[7:0]  = be[0] ? new_val[7:0]  : old_val[7:0];
      merge16[15:8] = be[1] ? new_val[15:8] : old_val[15:8];
    end
  endfunction

  // Address of one of the two indirect-access locations
  function is_indirect;
    input [15:0] addr;
    begin
      is_indirect = (addr[15:1] == 15'h0000);
    end
  endfunction

  // Address that has real storage in the local array
  function mem_hit;
    input [15:0] addr;
    begin
      mem_hit = ((addr >> MEM_AW) == 16'h0000) && !is_indirect(addr);
    end
  endfunction

  // ========================================================
  // State
  reg [7:0]                  mem [0:(1<<MEM_AW)-1];
  reg [`MAIAO_INSTR_W-1:0]   instr_last;
  reg [7:0]                  wreg;
  reg [7:0]                  status;
  reg [15:0]                 fsr0;
  reg [15:0]                 fsr1;
  reg [4:0]                  bank_select_register;
  reg [6:0]                  pc_high_latch;
  reg [15:0]                 mem_addr;
  reg                        ack;

  // ========================================================
  // Bus handshake: every access takes two cycles, so the answer
  // is always a flop and never a long combinational path.
  wire bus_req;
  wire wr_done;
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack;
  assign wr_done         = avs_write & ack;

  wire hit_instr;
  wire hit_wreg;
  wire hit_status;
  wire hit_fsr0;
  wire hit_fsr1;
  wire hit_bank;
  wire hit_page;
  wire hit_maddr;
  wire hit_mdata;

  // Register decode; low address bits ignored for word alignment
  // Whole byte offsets are compared with the two low bits forced
  // to zero, so both sides of each compare have the same width.
  assign hit_instr  = {avs_address[7:2], 2'b00} == `MAIAO_OFS_INSTR;
  assign hit_wreg   = {avs_address[7:2], 2'b00} == `MAIAO_OFS_WREG;
  assign hit_status = {avs_address[7:2], 2'b00} == `MAIAO_OFS_STATUS;
  assign hit_fsr0   = {avs_address[7:2], 2'b00} == `MAIAO_OFS_FSR0;
  assign hit_fsr1   = {avs_address[7:2], 2'b00} == `MAIAO_OFS_FSR1;
  assign hit_bank   = {avs_address[7:2], 2'b00} == `MAIAO_OFS_BANK;
  assign hit_page   = {avs_address[7:2], 2'b00} == `MAIAO_OFS_PAGE;
  assign hit_maddr  = {avs_address[7:2], 2'b00} == `MAIAO_OFS_MEM_ADDR;
  assign hit_mdata  = {avs_address[7:2], 2'b00} == `MAIAO_OFS_MEM_DATA;

  wire [31:0] wr_word;
  wire [31:0] instr_old;
  assign instr_old = {18'h00000, instr_last};
  assign wr_word   = be_merge(instr_old, avs_writedata, avs_byteenable);

  // ========================================================
  // Instruction field decode
  wire                      exec;
  wire [`MAIAO_INSTR_W-1:0] ins;
  wire [2:0]                opc;
  wire                      op_rel;
  wire                      sel;
  assign exec   = wr_done & hit_instr;
  assign ins    = wr_word[`MAIAO_INSTR_W-1:0];
  assign opc    = ins[`MAIAO_OP_HI:`MAIAO_OP_LO];
  assign op_rel = (opc == `MAIAO_OP_IRD_REL) ||
                  (opc == `MAIAO_OP_IWR_REL);
  // Pointer selector sits in a different bit for each form
  assign sel    = op_rel ? ins[`MAIAO_REL_SEL_BIT]
                         : ins[`MAIAO_MODE_SEL_BIT];

  wire [15:0] sel_ptr;
  wire [15:0] eff_addr;
  wire [15:0] ptr_after;
  assign sel_ptr = sel ? fsr1 : fsr0;

  maiao_ptr_unit u_ptr (
    .ptr                (sel_ptr),
    .pointer_mode_field (ins[1:0]),
    .rel_form           (op_rel),
    .rel_offset         (ins[5:0]),
    .eff_addr           (eff_addr),
    .next_ptr           (ptr_after)
  );

  // Store target: an indirect location redirects via its pointer
  wire [15:0] store_addr;
  assign store_addr = is_indirect({9'h000, ins[6:0]})
                    ? (ins[0] ? fsr1 : fsr0)
                    : {9'h000, ins[6:0]};

  // Reads of a location with no storage give zero; this also keeps
  // an indirect location from ever reading back a stored byte.
  wire [7:0] ind_byte;
  assign ind_byte = mem_hit(eff_addr)
                  ? mem[eff_addr[MEM_AW-1:0]]
                  : `MAIAO_RST_BYTE;

  // ========================================================
  // Next-state logic for the architectural registers
  reg [7:0]  next_wreg;
  reg [7:0]  next_status;
  reg [15:0] next_fsr0;
  reg [15:0] next_fsr1;
  reg [4:0]  next_bank;
  reg [6:0]  next_page;
  reg        mem_we;
  reg [15:0] mem_wa;
  reg [7:0]  mem_wd;

  always @* begin
    next_wreg   = wreg;
    next_status = status;
    next_fsr0   = fsr0;
    next_fsr1   = fsr1;
    next_bank   = bank_select_register;
    next_page   = pc_high_latch;
    mem_we      = 1'b0;
    mem_wa      = mem_addr;
    mem_wd      = wr_word[7:0];
    if (exec) begin
      case (opc)
        `MAIAO_OP_IRD, `MAIAO_OP_IRD_REL: begin
          next_wreg = ind_byte;
          next_status[`MAIAO_ST_Z_BIT] =
            (ind_byte == 8'h00);
        end
        `MAIAO_OP_IWR, `MAIAO_OP_IWR_REL: begin
          mem_we = mem_hit(eff_addr);
          mem_wa = eff_addr;
          mem_wd = wreg;
        end
        `MAIAO_OP_STORE: begin
          mem_we = mem_hit(store_addr);
          mem_wa = store_addr;
          mem_wd = wreg;
        end
        `MAIAO_OP_BANK: begin
          next_bank = ins[4:0];
        end
        `MAIAO_OP_PAGE: begin
          next_page = ins[6:0];
        end
        `MAIAO_OP_LIT: begin
          next_wreg = ins[7:0];
        end
        default: begin
          next_wreg = wreg;
        end
      endcase
      // Pointer update; status is left alone on this path
      if ((opc == `MAIAO_OP_IRD) || (opc == `MAIAO_OP_IWR)) begin
        if (sel) begin
          next_fsr1 = ptr_after;
        end else begin
          next_fsr0 = ptr_after;
        end
      end
    end else if (wr_done) begin
      // Direct software writes to the visible registers
      // W is one byte wide, so only lane 0 can reach it
      if (hit_wreg && avs_byteenable[0]) begin
        next_wreg = avs_writedata[7:0];
      end
      if (hit_status) begin
        next_status = {6'h00,
                       wr_word[`MAIAO_ST_C_BIT] & avs_byteenable[0],
                       wr_word[`MAIAO_ST_Z_BIT] & avs_byteenable[0]}
                    | (status & {8{~avs_byteenable[0]}});
      end
      // Pointers fill lanes 0 and 1; the upper lanes hold no bits
      if (hit_fsr0) begin
        next_fsr0 = merge16(fsr0, avs_writedata, avs_byteenable);
      end
      if (hit_fsr1) begin
        next_fsr1 = merge16(fsr1, avs_writedata, avs_byteenable);
      end
      if (hit_bank && avs_byteenable[0]) begin
        next_bank = avs_writedata[4:0];
      end
      if (hit_page && avs_byteenable[0]) begin
        next_page = avs_writedata[6:0];
      end
      // Direct window: indirect locations have no cells to write
      if (hit_mdata && avs_byteenable[0]) begin
        mem_we = mem_hit(mem_addr);
        mem_wa = mem_addr;
        mem_wd = avs_writedata[7:0];
      end
    end
  end

  // ========================================================
  // Read data mux, sampled into a flop on the request cycle
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (hit_instr) begin
      rd_mux = instr_old;
    end else if (hit_wreg) begin
      rd_mux = {24'h000000, wreg};
    end else if (hit_status) begin
      rd_mux = {24'h000000, status};
    end else if (hit_fsr0) begin
      rd_mux = {16'h0000, fsr0};
    end else if (hit_fsr1) begin
      rd_mux = {16'h0000, fsr1};
    end else if (hit_bank) begin
      rd_mux = {27'h0000000, bank_select_register};
    end else if (hit_page) begin
      rd_mux = {25'h0000000, pc_high_latch};
    end else if (hit_maddr) begin
      rd_mux = {16'h0000, mem_addr};
    end else if (hit_mdata) begin
      rd_mux = mem_hit(mem_addr)
             ? {24'h000000, mem[mem_addr[MEM_AW-1:0]]}
             : 32'h00000000;
    end
  end

  // ========================================================
  // Data memory: no reset, contents undefined until written
  always @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_wa[MEM_AW-1:0]] <= mem_wd;
    end
  end

  // ========================================================
  // Architectural registers and bus handshake flops
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack                  <= 1'b0;
      avs_readdata         <= 32'h00000000;
      instr_last           <= `MAIAO_RST_INSTR;
      wreg                 <= `MAIAO_RST_BYTE;
      status               <= `MAIAO_RST_BYTE;
      fsr0                 <= `MAIAO_RST_PTR;
      fsr1                 <= `MAIAO_RST_PTR;
      bank_select_register <= `MAIAO_RST_BANK;
      pc_high_latch        <= `MAIAO_RST_PAGE;
      mem_addr             <= `MAIAO_RST_PTR;
    end else begin
      ack                  <= bus_req & ~ack;
      if (avs_read && !ack) begin
        avs_readdata <= rd_mux;
      end
      if (exec) begin
        instr_last <= ins;
      end
      // Window address stays apart from the instruction path
      if (wr_done && hit_maddr) begin
        mem_addr <= merge16(mem_addr, avs_writedata, avs_byteenable);
      end
      wreg                 <= next_wreg;
      status               <= next_status;
      fsr0                 <= next_fsr0;
      fsr1                 <= next_fsr1;
      bank_select_register <= next_bank;
      pc_high_latch        <= next_page;
    end
  end

endmodule
`default_nettype wire

// *** core/maiao_defs.vh ***
// Purpose: Shared constants for the data-move execution block.
// Assumes: Included by bare name from every core file.
// Notes:   Definitions only; no logic lives here.
`ifndef MAIAO_DEFS_VH
`define MAIAO_DEFS_VH

// ==========================================================
// Register byte offsets on the Avalon-MM slave
`define MAIAO_OFS_INSTR      8'h00
`define MAIAO_OFS_WREG       8'h04
`define MAIAO_OFS_STATUS     8'h08
`define MAIAO_OFS_FSR0       8'h0c
`define MAIAO_OFS_FSR1       8'h10
`define MAIAO_OFS_BANK       8'h14
`define MAIAO_OFS_PAGE       8'h18
`define MAIAO_OFS_MEM_ADDR   8'h1c
`define MAIAO_OFS_MEM_DATA   8'h20

// ==========================================================
// Instruction word layout
`define MAIAO_INSTR_W        14
`define MAIAO_OP_HI          13
`define MAIAO_OP_LO          11
`define MAIAO_OP_STORE       3'h0
`define MAIAO_OP_IRD         3'h1
`define MAIAO_OP_IWR         3'h2
`define MAIAO_OP_IRD_REL     3'h3
`define MAIAO_OP_IWR_REL     3'h4
`define MAIAO_OP_BANK        3'h5
`define MAIAO_OP_PAGE        3'h6
`define MAIAO_OP_LIT         3'h7
`define MAIAO_MODE_SEL_BIT   2
`define MAIAO_REL_SEL_BIT    6

// ==========================================================
// Pointer mode field codes
`define MAIAO_MM_PREINC      2'h0
`define MAIAO_MM_PREDEC      2'h1
`define MAIAO_MM_POSTINC     2'h2
`define MAIAO_MM_POSTDEC     2'h3

// ==========================================================
// Status bits and reset values
`define MAIAO_ST_Z_BIT       0
`define MAIAO_ST_C_BIT       1
`define MAIAO_RST_BYTE       8'h00
`define MAIAO_RST_PTR        16'h0000
`define MAIAO_RST_BANK       5'h00
`define MAIAO_RST_PAGE       7'h00
`define MAIAO_RST_INSTR      14'h0000

`endif

// *** core/maiao_ptr_unit.v ***
// Purpose: Effective address and next pointer for indirect moves.
// Assumes: Purely combinational; caller selects the pointer.
// Notes:   16-bit sums wrap on their own, which gives modulo 65536.
`timescale 1ns/1ns
`default_nettype none
`include "maiao_defs.vh"

module maiao_ptr_unit (
  // Selected pointer and addressing form
  input  wire [15:0] ptr,
  input  wire [1:0]  pointer_mode_field,
  input  wire        rel_form,
  input  wire [5:0]  rel_offset,
  // Results
  output reg  [15:0] eff_addr,
  output reg  [15:0] next_ptr
);

  wire [15:0] ptr_inc;
  wire [15:0] ptr_dec;
  wire [15:0] ptr_rel;

  // Wrap-around falls out of the fixed 16-bit width
  assign ptr_inc = ptr + 16'h0001;
  assign ptr_dec = ptr - 16'h0001;
  assign ptr_rel = ptr + {{10{rel_offset[5]}}, rel_offset};

  // ========================================================
  // Mode decode
  always @* begin
    eff_addr = ptr;
    next_ptr = ptr;
    if (rel_form) begin
      eff_addr = ptr_rel;
      next_ptr = ptr;
    end else begin
      case (pointer_mode_field)
        `MAIAO_MM_PREINC: begin
          eff_addr = ptr_inc;
          next_ptr = ptr_inc;
        end
        `MAIAO_MM_PREDEC: begin
          eff_addr = ptr_dec;
          next_ptr = ptr_dec;
        end
        `MAIAO_MM_POSTINC: begin
          eff_addr = ptr;
          next_ptr = ptr_inc;
        end
        `MAIAO_MM_POSTDEC: begin
          eff_addr = ptr;
          next_ptr = ptr_dec;
        end
        default: begin
          eff_addr = ptr;
          next_ptr = ptr;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** tb/maiao_core_asserts.sv ***
// Purpose: Port-level checks on the data-move block's slave bus.
// Assumes: Master holds each request until waitrequest is low.
// Notes:   Widths of W, status, pointers, bank and page are checked on each completed read.
`timescale 1ns/1ns
`default_nettype none

module maiao_core_asserts #(
  parameter MEM_AW = 8
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // Slave bus
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // =========================================================
  // Request phases
  sequence s_busy; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ack; (avs_read || avs_write) && !avs_waitrequest; endsequence
  sequence s_rd_ack; avs_read && !avs_waitrequest; endsequence

  // =========================================================
  // Handshake timing
  a_idle_no_wait: assert property (!(avs_read || avs_write) |->
    !avs_waitrequest) else $error("waitrequest high while idle");
  a_fresh_waits: assert property ((avs_read || avs_write) &&
    !$past(avs_read || avs_write) |-> avs_waitrequest)
    else $error("new request not held off");
  a_one_wait: assert property (s_busy |=> !avs_waitrequest)
    else $error("answer not one cycle after request");
  a_ack_once: assert property (s_ack |=>
    (!(avs_read || avs_write) || avs_waitrequest))
    else $error("acknowledge lasted two cycles");
  // Read data must not drift between reads
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  // =========================================================
  // Read data shape per register
  a_unmapped_zero: assert property (s_rd_ack ##0 avs_address[7:2] > 6'h08
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_w_width: assert property (
    s_rd_ack ##0 avs_address[7:2] == 6'h01 |-> avs_readdata[31:8] == 24'h0)
    else $error("W wider than a byte");
  a_status_width: assert property (
    s_rd_ack ##0 avs_address[7:2] == 6'h02 |-> avs_readdata[31:2] == 30'h0)
    else $error("status has stray bits");
  a_ptr_width: assert property (
    s_rd_ack ##0 (avs_address[7:2] == 6'h03 || avs_address[7:2] == 6'h04)
    |-> avs_readdata[31:16] == 16'h0) else $error("pointer over 16 bits");
  a_bank_width: assert property (
    s_rd_ack ##0 avs_address[7:2] == 6'h05 |-> avs_readdata[31:5] == 27'h0)
    else $error("bank register over 5 bits");
  a_page_width: assert property (
    s_rd_ack ##0 avs_address[7:2] == 6'h06 |-> avs_readdata[31:7] == 25'h0)
    else $error("page latch over 7 bits");
endmodule

bind maiao_core maiao_core_asserts #(.MEM_AW(MEM_AW)) i_maiao_core_asserts (
  .mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// *** tb/maiao_core_bench.sv ***
// Purpose: Self-checking bench for the data-move block.
// Assumes: MEM_AW of 8; memory is filled before any indirect access.
// Notes:   A shadow model predicts every register and touched byte.
`timescale 1ns/1ns
`default_nettype none
`include "maiao_defs.vh"

module maiao_core_bench;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          fail_count = 0;
  int          cmp_count = 0;
  logic [7:0]  mem [0:255];
  logic [15:0] fsr [0:1];
  logic [7:0]  w;
  logic [4:0]  bank;
  logic [6:0]  page;
  logic        z;
  logic        c;
  logic [15:0] last_ea;
  logic [31:0] rd;
  logic [31:0] v;

  always #5 mclk = ~mclk;

  maiao_core #(.MEM_AW(8)) i_maiao_core (.mclk(mclk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // =========================================================
  // Verdict, compare and bus access
  task close_out;
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Idle edge first, so a release is never followed by a raise in one step
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Wait low and read data are taken at one rising edge; the hang
    // guard alone ends a wait that never finishes
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // =========================================================
  // Shadow model
  function automatic logic [7:0] mrd(input logic [15:0] a);
    return (a > 16'h1 && a < 16'h100) ? mem[a[7:0]] : 8'h00;
  endfunction

  task setp(input logic n, input logic [15:0] p);
    fsr[n] = p;
    bus(1'b1, n ? `MAIAO_OFS_FSR1 : `MAIAO_OFS_FSR0, {16'h0, p});
  endtask

  task mexec(input logic [13:0] ins);
    logic [15:0] p;
    logic [15:0] np;
    logic [15:0] ea;
    ea = last_ea;
    case (ins[13:11])
      3'h0: ea = (ins[6:1] == 6'h0) ? fsr[ins[0]] : {9'h0, ins[6:0]};
      3'h1, 3'h2: begin
        p = fsr[ins[2]];
        np = ins[0] ? p - 16'h1 : p + 16'h1;
        ea = ins[1] ? p : np;
        fsr[ins[2]] = np;
      end
      3'h3, 3'h4: ea = fsr[ins[6]] + {{10{ins[5]}}, ins[5:0]};
      3'h5: bank = ins[4:0];
      3'h6: page = ins[6:0];
      default: w = ins[7:0];
    endcase
    if (ins[13:11] == 3'h1 || ins[13:11] == 3'h3) begin
      w = mrd(ea);
      z = (w == 8'h00);
    end
    if ((ins[13:11] == 3'h0 || ins[13:11] == 3'h2 || ins[13:11] == 3'h4)
        && ea > 16'h1 && ea < 16'h100)
      mem[ea[7:0]] = w;
    last_ea = ea;
    bus(1'b1, `MAIAO_OFS_INSTR, {18'h0, ins});
  endtask

  task chkall;
    bus(1'b0, `MAIAO_OFS_WREG, 32'h0);
    chk(rd, {24'h0, w});
    bus(1'b0, `MAIAO_OFS_STATUS, 32'h0);
    chk(rd, {30'h0, c, z});
    bus(1'b0, `MAIAO_OFS_FSR0, 32'h0);
    chk(rd, {16'h0, fsr[0]});
    bus(1'b0, `MAIAO_OFS_FSR1, 32'h0);
    chk(rd, {16'h0, fsr[1]});
    bus(1'b0, `MAIAO_OFS_BANK, 32'h0);
    chk(rd, {27'h0, bank});
    bus(1'b0, `MAIAO_OFS_PAGE, 32'h0);
    chk(rd, {25'h0, page});
    bus(1'b1, `MAIAO_OFS_MEM_ADDR, {16'h0, last_ea});
    bus(1'b0, `MAIAO_OFS_MEM_DATA, 32'h0);
    chk(rd, {24'h0, mrd(last_ea)});
  endtask

  // =========================================================
  // Main sequence
  initial begin
    v = $urandom(32'h2e92);
    {w, z, c, bank, page} = '0;
    fsr[0] = 16'h0;
    fsr[1] = 16'h0;
    last_ea = 16'h2;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    // Memory wakes unknown, so give every real byte a value
    for (int i = 2; i < 256; i++) begin
      mem[i] = 8'($urandom);
      bus(1'b1, `MAIAO_OFS_MEM_ADDR, i);
      bus(1'b1, `MAIAO_OFS_MEM_DATA, {24'h0, mem[i]});
    end
    chkall();
    bus(1'b0, `MAIAO_OFS_INSTR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'h40, 32'hffffffff);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    // Carry set by software must survive every move
    c = 1'b1;
    bus(1'b1, `MAIAO_OFS_STATUS, 32'h2);
    setp(1'b0, 16'hffff);
    mexec({3'h1, 8'h0, 1'b0, 2'h0});
    bus(1'b0, `MAIAO_OFS_FSR0, 32'h0);
    chk(rd, 32'h0);
    setp(1'b1, 16'h0000);
    mexec({3'h2, 8'h0, 1'b1, 2'h1});
    bus(1'b0, `MAIAO_OFS_FSR1, 32'h0);
    chk(rd, 32'hffff);
    setp(1'b0, 16'h0040);
    mexec({3'h3, 4'h0, 1'b0, 6'h20});
    bus(1'b0, `MAIAO_OFS_WREG, 32'h0);
    chk(rd, {24'h0, mem[8'h20]});
    setp(1'b1, 16'h0080);
    mexec({3'h4, 4'h0, 1'b1, 6'h1f});
    chkall();
    mem[8'h50] = 8'h00;
    bus(1'b1, `MAIAO_OFS_MEM_ADDR, 32'h50);
    bus(1'b1, `MAIAO_OFS_MEM_DATA, 32'h0);
    setp(1'b0, 16'h0050);
    mexec({3'h3, 4'h0, 1'b0, 6'h0});
    bus(1'b0, `MAIAO_OFS_STATUS, 32'h0);
    chk(rd, 32'h3);
    // Both pointers, all four modes, read and write
    for (int i = 0; i < 16; i++) begin
      setp(i[2], 16'h0080);
      mexec({i[3] ? 3'h2 : 3'h1, 8'h0, i[2:0]});
      bus(1'b0, i[2] ? `MAIAO_OFS_FSR1 : `MAIAO_OFS_FSR0, 32'h0);
      chk(rd, {16'h0, fsr[i[2]]});
      chkall();
    end
    mexec({3'h7, 3'h0, 8'hff});
    bus(1'b0, `MAIAO_OFS_WREG, 32'h0);
    chk(rd, 32'hff);
    mexec({3'h5, 6'h0, 5'h1f});
    mexec({3'h6, 4'h0, 7'h7f});
    mexec({3'h0, 4'h0, 7'h7f});
    bus(1'b1, `MAIAO_OFS_MEM_ADDR, 32'h7f);
    bus(1'b0, `MAIAO_OFS_MEM_DATA, 32'h0);
    chk(rd, {24'h0, w});
    setp(1'b0, 16'h0033);
    mexec(14'h0000);
    chkall();
    // Random traffic, pointers biased into the memory window
    repeat (300) begin
      v = $urandom;
      if (v[31:29] == 3'h0)
        setp(v[16], v[20] ? {8'h0, v[7:0]} : v[15:0]);
      mexec(14'($urandom));
      chkall();
    end
    close_out();
  end

  // Hang guard, far beyond the expected run
  initial begin
    #400000;
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
